// File: pmsi_pkg.sv
// Purpose: shared constants for the power control and slot identification registers
// Assumes: dword-addressed configuration space, byte enables per lane
// Notes: offsets are byte addresses of the aligned dwords
package pmsi_pkg;
  localparam logic [7:0] PMSI_OFF_PM_CSR = 8'h94;
  localparam logic [7:0] PMSI_OFF_RSVD0 = 8'h98;
  localparam logic [7:0] PMSI_OFF_RSVD1 = 8'h9c;
  localparam logic [7:0] PMSI_OFF_SLOT = 8'ha0;
  localparam int PMSI_PS_LSB = 0;
  localparam int PMSI_WAKE_EN_BIT = 8;
  localparam int PMSI_WAKE_ST_BIT = 15;
  localparam int PMSI_B2B3_BIT = 22;
  localparam int PMSI_BPCC_BIT = 23;
  localparam int PMSI_SLOTNUM_LSB = 16;
  localparam int PMSI_FIC_BIT = 21;
  localparam int PMSI_CHASSIS_LSB = 24;
  localparam logic [1:0] PMSI_PS_D0 = 2'h0;
  localparam logic [1:0] PMSI_PS_D1 = 2'h1;
  localparam logic [1:0] PMSI_PS_D2 = 2'h2;
  localparam logic [1:0] PMSI_PS_D3 = 2'h3;
  localparam logic [7:0] PMSI_CAP_ID = 8'h04;
  localparam logic [7:0] PMSI_NEXT_PTR = 8'hb0;
  localparam logic [4:0] PMSI_SLOTNUM_RST = 5'h00;
  localparam logic [7:0] PMSI_CHASSIS_RST = 8'h00;
  localparam logic PMSI_B2B3_VAL = 1'b0;
  localparam logic PMSI_BPCC_VAL = 1'b0;
  localparam int PMSI_DEV_RST_CYCLES = 4;
endpackage

// File: pmsi_sync.sv
// Purpose: two flip-flop synchroniser for asynchronous levels
// Assumes: input is a quasi-static level
// Notes: first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module pmsi_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      q <= '0;
    end else begin
      s1_q <= d;
      q <= s1_q;
    end
  end
endmodule
`default_nettype wire

// File: pmsi_dev_reset.sv
// Purpose: stretches a one-cycle request into an internal device reset pulse
// Assumes: req is synchronous to clk
// Notes: never touches the parallel bus reset pin
`timescale 1ns/1ps
`default_nettype none
module pmsi_dev_reset #(
  parameter int CYCLES = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req,
  output logic dev_rst
);
  logic [7:0] cnt_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
      dev_rst <= 1'b0;
    end else if (req) begin
      cnt_q <= 8'(CYCLES - 1);
      dev_rst <= 1'b1;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end else begin
      dev_rst <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: pmsi_regs.sv
// Purpose: power control/status, bridge extension and slot identification registers
// Assumes: config accesses are one-cycle strobes on clk; aux_rst_n is the power-on reset of sticky bits
// Notes: read data is registered and valid the cycle after rd_en
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - The power state lives in bits 1:0, 00 is D0 and 11 is D3, and resets to D0.
// - Writes of the D1 or D2 code to the power state are dropped and the state is kept.
// - A software write taking the state from D3 to D0 fires an internal reset, never the bus reset pin.
// - The sticky wake enable at bit 8, reset 0, gates the wake event output.
// - Data select, data scale and the data byte read zero and ignore writes.
// - Bit 22 of the bridge extension reads 0.
// - Bit 23 of the bridge extension reads 0 and ignores writes.
// - The slot identification slot_ident_cap_id reads 04h in bits 7:0.
// - The slot identification capability is off after reset and enabled only by the loader.
// - The slot identification next pointer reads B0h in bits 15:8.
// - Slot number at 20:16 and first-in-chassis at 21 are writable, reset 0; bits 23:22 read zero.
// - The chassis number at 31:24 is writable and resets to 00h.
// - Wake events may be signalled in D0, D3hot and D3cold.
module pmsi_regs #(
  parameter int DEV_RST_CYCLES = pmsi_pkg::PMSI_DEV_RST_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic aux_rst_n,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [3:0] byte_en,
  input wire logic [31:0] wr_data,
  input wire logic wake_event_in,
  input wire logic loader_si_en,
  input wire logic loader_si_we,
  output logic [31:0] rd_data,
  output logic si_cap_present,
  output logic [1:0] power_state,
  output logic dev_reset,
  output logic wake_event_out_n
);
  logic rst_s1_q, rst_sync_q;
  logic aux_s1_q, aux_sync_q;
  logic wake_sync, ld_en_sync, ld_we_sync;
  logic wake_d1_q;
  logic [1:0] ps_q;
  logic wake_en_q, wake_st_q;
  logic si_en_q;
  logic [4:0] slot_num_q;
  logic fic_q;
  logic [7:0] chassis_q;
  logic wr_pm, wr_slot, ps_wr_ok, d3_to_d0, wake_rise;
  logic [31:0] rd_d;
  logic dev_rst;

  // reset release through two flops, sticky domain separately
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_sync_q <= rst_s1_q;
    end
  end

  always_ff @(posedge clk or negedge aux_rst_n) begin
    if (!aux_rst_n) begin
      aux_s1_q <= 1'b0;
      aux_sync_q <= 1'b0;
    end else begin
      aux_s1_q <= 1'b1;
      aux_sync_q <= aux_s1_q;
    end
  end

  pmsi_sync #(.W(3)) u_sync (
    .clk(clk),
    .rst_n(aux_sync_q),
    .d({wake_event_in, loader_si_en, loader_si_we}),
    .q({wake_sync, ld_en_sync, ld_we_sync})
  );

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction

  assign wr_pm = wr_en && hit(addr, pmsi_pkg::PMSI_OFF_PM_CSR);
  assign wr_slot = wr_en && hit(addr, pmsi_pkg::PMSI_OFF_SLOT) && si_en_q;
  assign ps_wr_ok = wr_pm && byte_en[0] && (wr_data[1:0] == pmsi_pkg::PMSI_PS_D0 ||
                    wr_data[1:0] == pmsi_pkg::PMSI_PS_D3);
  assign d3_to_d0 = ps_wr_ok && ps_q == pmsi_pkg::PMSI_PS_D3 &&
                    wr_data[1:0] == pmsi_pkg::PMSI_PS_D0;
  assign wake_rise = wake_sync && !wake_d1_q;

  // power state, cleared only by the synchronised reset, not by the internal reset
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      ps_q <= pmsi_pkg::PMSI_PS_D0;
    end else if (ps_wr_ok) begin
      ps_q <= wr_data[1:0];
    end
  end

  // sticky bits survive ordinary resets
  always_ff @(posedge clk or negedge aux_sync_q) begin
    if (!aux_sync_q) begin
      wake_en_q <= 1'b0;
      wake_st_q <= 1'b0;
      wake_d1_q <= 1'b0;
    end else begin
      wake_d1_q <= wake_sync;
      if (wr_pm && byte_en[1]) begin
        wake_en_q <= wr_data[pmsi_pkg::PMSI_WAKE_EN_BIT];
      end
      // any power state may raise it; set wins over clear
      if (wake_rise) begin
        wake_st_q <= 1'b1;
      end else if (wr_pm && byte_en[1] && wr_data[pmsi_pkg::PMSI_WAKE_ST_BIT]) begin
        wake_st_q <= 1'b0;
      end
    end
  end

  // capability enable only from the loader
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      si_en_q <= 1'b0;
    end else if (ld_we_sync) begin
      si_en_q <= ld_en_sync;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      slot_num_q <= pmsi_pkg::PMSI_SLOTNUM_RST;
      fic_q <= 1'b0;
      chassis_q <= pmsi_pkg::PMSI_CHASSIS_RST;
    end else if (dev_rst) begin
      slot_num_q <= pmsi_pkg::PMSI_SLOTNUM_RST;
      fic_q <= 1'b0;
      chassis_q <= pmsi_pkg::PMSI_CHASSIS_RST;
    end else if (wr_slot) begin
      if (byte_en[2]) begin
        slot_num_q <= wr_data[pmsi_pkg::PMSI_SLOTNUM_LSB +: 5];
        fic_q <= wr_data[pmsi_pkg::PMSI_FIC_BIT];
      end
      if (byte_en[3]) begin
        chassis_q <= wr_data[pmsi_pkg::PMSI_CHASSIS_LSB +: 8];
      end
    end
  end

  pmsi_dev_reset #(.CYCLES(DEV_RST_CYCLES)) u_dev_rst (
    .clk(clk),
    .rst_n(rst_sync_q),
    .req(d3_to_d0),
    .dev_rst(dev_rst)
  );

  always_comb begin
    rd_d = 32'h0000_0000;
    if (hit(addr, pmsi_pkg::PMSI_OFF_PM_CSR)) begin
      rd_d[pmsi_pkg::PMSI_PS_LSB +: 2] = ps_q;
      rd_d[pmsi_pkg::PMSI_WAKE_EN_BIT] = wake_en_q;
      rd_d[pmsi_pkg::PMSI_WAKE_ST_BIT] = wake_st_q;
      rd_d[pmsi_pkg::PMSI_B2B3_BIT] = pmsi_pkg::PMSI_B2B3_VAL;
      rd_d[pmsi_pkg::PMSI_BPCC_BIT] = pmsi_pkg::PMSI_BPCC_VAL;
    end else if (hit(addr, pmsi_pkg::PMSI_OFF_SLOT) && si_en_q) begin
      rd_d[7:0] = pmsi_pkg::PMSI_CAP_ID;
      rd_d[15:8] = pmsi_pkg::PMSI_NEXT_PTR;
      rd_d[pmsi_pkg::PMSI_SLOTNUM_LSB +: 5] = slot_num_q;
      rd_d[pmsi_pkg::PMSI_FIC_BIT] = fic_q;
      rd_d[pmsi_pkg::PMSI_CHASSIS_LSB +: 8] = chassis_q;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      rd_data <= 32'h0000_0000;
    end else if (rd_en) begin
      rd_data <= rd_d;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      si_cap_present <= 1'b0;
      power_state <= pmsi_pkg::PMSI_PS_D0;
      dev_reset <= 1'b0;
    end else begin
      si_cap_present <= si_en_q;
      power_state <= ps_q;
      dev_reset <= dev_rst;
    end
  end

  // wake pin held in the sticky domain
  always_ff @(posedge clk or negedge aux_sync_q) begin
    if (!aux_sync_q) begin
      wake_event_out_n <= 1'b1;
    end else begin
      wake_event_out_n <= !(wake_en_q && wake_st_q);
    end
  end
endmodule
`default_nettype wire

// File: pmsi_regs_checker.sv
// Purpose: port-level checks for pmsi_regs
// Assumes: bound to every pmsi_regs instance
// Notes: run_q measures the internal reset pulse
`timescale 1ns/1ps
`default_nettype none
module pmsi_regs_checker #(
  parameter int DEV_RST_CYCLES = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic aux_rst_n,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [3:0] byte_en,
  input wire logic [31:0] wr_data,
  input wire logic wake_event_in,
  input wire logic loader_si_en,
  input wire logic loader_si_we,
  input wire logic [31:0] rd_data,
  input wire logic si_cap_present,
  input wire logic [1:0] power_state,
  input wire logic dev_reset,
  input wire logic wake_event_out_n
);
  logic [8:0] run_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) run_q <= 9'h0;
    else run_q <= dev_reset ? run_q + 9'h1 : 9'h0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence d3_exit_s;
    power_state == 2'h3 && wr_en && addr == 8'h94 && byte_en[0] && wr_data[1:0] == 2'h0;
  endsequence
  sequence en_clr_s;
    wr_en && addr == 8'h94 && byte_en[1] && !wr_data[8];
  endsequence
  sequence slot_rd_s;
    rd_en && addr == 8'ha0;
  endsequence
  ps_legal_a: assert property (power_state != 2'h1 && power_state != 2'h2)
    else $error("illegal power state");
  rst_start_a: assert property (d3_exit_s |-> ##2 dev_reset)
    else $error("no reset after leaving D3");
  rst_cause_a: assert property ($rose(dev_reset) |-> $past(wr_en, 2) && $past(addr, 2) == 8'h94)
    else $error("reset without power write");
  rst_len_a: assert property ($fell(dev_reset) |-> run_q == DEV_RST_CYCLES)
    else $error("reset pulse length wrong");
  wake_off_a: assert property (disable iff (!aux_rst_n) en_clr_s |-> ##[1:3] wake_event_out_n)
    else $error("wake output low while disabled");
  rd_pm_a: assert property (rd_en && addr == 8'h94 |=> rd_data[31:16] == 16'h0 && rd_data[14:9] == 6'h0)
    else $error("power word fixed bits not zero");
  rd_slot_a: assert property (slot_rd_s ##0 si_cap_present |=> rd_data[15:0] == 16'hb004 && rd_data[23:22] == 2'h0)
    else $error("slot word fixed bits wrong");
  si_off_a: assert property (slot_rd_s ##0 !si_cap_present |=> rd_data == 32'h0)
    else $error("slot word visible while off");
endmodule
`default_nettype wire

// File: power_mgmt_slot_id_cap_regs_test.sv
// Purpose: self-checking bench for pmsi_regs
// Assumes: inputs change on rising edges by non-blocking assignment
// Notes: short internal reset pulse through DEV_RST_CYCLES
`timescale 1ns/1ps
`default_nettype none
module power_mgmt_slot_id_cap_regs_test;
  localparam int NR = 3;
  logic clk = 1'b0, rst_n = 1'b0, aux_rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, wake_event_in = 1'b0;
  logic loader_si_en = 1'b0, loader_si_we = 1'b0, si_cap_present, dev_reset, wake_event_out_n;
  logic [7:0] addr = 8'h00;
  logic [3:0] byte_en = 4'h0;
  logic [31:0] wr_data = 32'h0, rd_data, got, r, slot_m = 32'h0000b004;
  logic [1:0] power_state, ps_m = 2'h0;
  logic [1:0] codes [5] = '{2'h1, 2'h2, 2'h3, 2'h1, 2'h2};
  logic [7:0] offs [3] = '{8'ha0, 8'h98, 8'h9c};
  int err_total = 0, total_checks = 0, cyc = 0, n;
  pmsi_regs #(.DEV_RST_CYCLES(NR)) dut (.clk(clk), .rst_n(rst_n), .aux_rst_n(aux_rst_n), .wr_en(wr_en),
    .rd_en(rd_en), .addr(addr), .byte_en(byte_en), .wr_data(wr_data), .wake_event_in(wake_event_in),
    .loader_si_en(loader_si_en), .loader_si_we(loader_si_we), .rd_data(rd_data), .si_cap_present(si_cap_present),
    .power_state(power_state), .dev_reset(dev_reset), .wake_event_out_n(wake_event_out_n));
  always #5 clk = ~clk;
  task automatic tally_and_finish();
    if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      $display("mismatch at %0t: timeout", $time);
      tally_and_finish();
    end
  end
  task automatic chk(logic [31:0] g, logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] be);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    byte_en <= be;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    @(posedge clk);
    #1 got = rd_data;
  endtask
  task automatic wake();
    @(posedge clk);
    wake_event_in <= 1'b1;
    repeat (4) @(posedge clk);
    wake_event_in <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask
  // slot word after a write: only the writable fields of enabled lanes change
  function automatic logic [31:0] slot_f(logic [31:0] o, logic [31:0] d, logic [3:0] be);
    slot_f = o;
    if (be[2]) slot_f[21:16] = d[21:16];
    if (be[3]) slot_f[31:24] = d[31:24];
  endfunction
  initial begin
    n = $urandom(12);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    aux_rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(8'h94);
    chk(got, 32'h0);
    foreach (offs[i]) begin
      rd(offs[i]);
      chk(got, 32'h0);
    end
    chk({31'h0, si_cap_present}, 32'h0);
    loader_si_en <= 1'b1;
    loader_si_we <= 1'b1;
    repeat (4) @(posedge clk);
    loader_si_we <= 1'b0;
    repeat (4) @(posedge clk);
    rd(8'ha0);
    chk(got, slot_m);
    chk({31'h0, si_cap_present}, 32'h1);
    repeat (8) begin
      r = $urandom;
      n = $urandom_range(15);
      wr(8'ha0, r, n[3:0]);
      slot_m = slot_f(slot_m, r, n[3:0]);
      rd(8'ha0);
      chk(got, slot_m);
    end
    foreach (codes[i]) begin
      r = $urandom & 32'hfffffefc | codes[i];
      wr(8'h94, r, 4'hd);
      ps_m = (codes[i] == 2'h1 || codes[i] == 2'h2) ? ps_m : codes[i];
      rd(8'h94);
      chk(got, {30'h0, ps_m});
      chk({30'h0, power_state}, {30'h0, ps_m});
    end
    wr(8'h94, 32'h0, 4'h1);
    n = 0;
    repeat (NR + 4) begin
      @(posedge clk);
      #1 if (dev_reset === 1'b1) n++;
    end
    chk(n, NR);
    rd(8'ha0);
    chk(got & 32'hffff0000, 32'h0);
    wr(8'h94, 32'h100, 4'h2);
    wake();
    chk({31'h0, wake_event_out_n}, 32'h0);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(8'ha0);
    chk(got, 32'h0);
    chk({31'h0, si_cap_present}, 32'h0);
    rd(8'h94);
    chk(got, 32'h8100);
    wr(8'h94, 32'h8000, 4'h2);
    rd(8'h94);
    chk(got, 32'h0);
    wr(8'h94, 32'h3, 4'h1);
    wake();
    chk({31'h0, wake_event_out_n}, 32'h1);
    rd(8'h94);
    chk(got, 32'h8003);
    tally_and_finish();
  end
endmodule
bind pmsi_regs pmsi_regs_checker #(.DEV_RST_CYCLES(DEV_RST_CYCLES)) chk_i (.clk(clk), .rst_n(rst_n),
  .aux_rst_n(aux_rst_n), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .byte_en(byte_en), .wr_data(wr_data),
  .wake_event_in(wake_event_in), .loader_si_en(loader_si_en), .loader_si_we(loader_si_we), .rd_data(rd_data),
  .si_cap_present(si_cap_present), .power_state(power_state), .dev_reset(dev_reset),
  .wake_event_out_n(wake_event_out_n));
`default_nettype wire
